// file: ccl_analog_model.sv
`default_nettype none

module ccl_analog_model #(
	parameter int BG_MV = 1000
) (
	input  wire logic                  dis_i,
	input  wire logic                  bg_i,
	input  wire ccl_pkg::ccl_neg_sel_s sel_i,
	input  var  int                    pos_mv_i,
	input  var  int                    neg_mv_i,
	output logic                       raw_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import ccl_pkg::*;

	int p;
	int n;

	// Converter pins sit on a 100 mV ladder so each channel gives a distinct level
	always_comb begin
		p = bg_i ? BG_MV : pos_mv_i;
		// The converter mux is taken as powered up whenever selected
		n = sel_i.use_mux ? 100 * int'(sel_i.channel) : neg_mv_i;
		raw_o = !dis_i && (p > n);
	end
endmodule : ccl_analog_model

`default_nettype wire

// file: ccl_cfg.svh
`ifndef CCL_CFG_SVH
`define CCL_CFG_SVH

// Register indices; the APB byte address is four times the index
`define CCL_IDX_CONV_CTRL_B     10'h07b
`define CCL_IDX_CTRL_STATUS     10'h050
`define CCL_IDX_PIN_IN_DISABLE  10'h07f

// converter_ctrl_b fields
`define CCL_CB_MUX_EN           6
`define CCL_CB_SEL_HI           3
`define CCL_CB_TRIG_HI          2
`define CCL_CB_TRIG_LO          0

// comparator_ctrl_status fields
`define CCL_CS_DISABLE          7
`define CCL_CS_BANDGAP          6
`define CCL_CS_RESULT           5
`define CCL_CS_FLAG             4
`define CCL_CS_IRQ_EN           3
`define CCL_CS_CAPTURE          2
`define CCL_CS_MODE_HI          1
`define CCL_CS_MODE_LO          0

// comparator_pin_input_disable fields
`define CCL_PD_NEG              1
`define CCL_PD_POS              0

// Reset values
`define CCL_CB_RESET            8'h00
`define CCL_PD_RESET            2'h0
`define CCL_WORD_ZERO           32'h0000_0000

`endif

// file: ccl_comparator_ctrl.sv
// Chosen here: the APB interface to the registers.
`default_nettype none
`include "ccl_cfg.svh"

module ccl_comparator_ctrl (
	input  wire logic                  clk_i,
	input  wire logic                  nrst_i,
	// APB slave
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [11:0]           paddr_i,
	input  wire logic [31:0]           pwdata_i,
	input  wire logic [3:0]            pstrb_i,
	output logic      [31:0]           prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	// Analog comparator core
	input  wire logic                  cmp_raw_i,
	output logic                       comparator_disable_o,
	output logic                       bandgap_select_o,
	output ccl_pkg::ccl_neg_sel_s      neg_sel_o,
	// Converter side, same clock
	input  wire logic                  converter_enable_i,
	input  wire logic [2:0]            neg_select_low_i,
	output logic      [2:0]            trigger_src_o,
	// Processor core, same clock
	input  wire logic                  global_irq_enable_i,
	input  wire logic                  irq_vector_ack_i,
	output logic                       irq_o,
	// Timer capture front end
	output logic                       capture_o,
	// Comparator pins, digital path
	input  wire logic                  positive_pin_i,
	input  wire logic                  negative_pin_i,
	output logic                       pos_pin_buffer_off_o,
	output logic                       neg_pin_buffer_off_o,
	output logic                       positive_pin_o,
	output logic                       negative_pin_o
);
	import ccl_pkg::*;

	// Synchronisers and edge history
	logic        cmp_meta;
	logic        cmp_result;
	logic        cmp_prev;
	logic        pos_meta;
	logic        pos_sync;
	logic        neg_meta;
	logic        neg_sync;
	logic        next_cmp_meta;
	logic        next_cmp_result;
	logic        next_cmp_prev;
	logic        next_pos_meta;
	logic        next_pos_sync;
	logic        next_neg_meta;
	logic        next_neg_sync;

	// Register state
	ccl_ctrl_s   ctrl;
	ccl_ctrl_s   next_ctrl;
	ccl_conv_b_s conv_b;
	ccl_conv_b_s next_conv_b;
	logic [1:0]  pin_dis;
	logic [1:0]  next_pin_dis;

	// Bus outputs
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;

	// Outputs to the outside world
	logic        next_irq;
	logic        next_capture;
	logic        next_positive_pin;
	logic        next_negative_pin;
	ccl_neg_sel_s next_neg_sel;

	// Decode helpers
	logic        hit_cb;
	logic        hit_cs;
	logic        hit_pd;
	logic        mapped;
	logic        commit;
	logic        wr_lane0;
	logic        event_hit;
	logic        flag_clear;
	logic [7:0]  cs_read;
	logic [7:0]  cb_read;

	// ---------------------------------------------------------------
	// Synchronisers: first stage feeds only the second
	// ---------------------------------------------------------------
	always_comb begin
		next_cmp_meta   = cmp_raw_i;
		next_cmp_result = cmp_meta;
		next_cmp_prev   = cmp_result;
		next_pos_meta   = positive_pin_i;
		next_pos_sync   = pos_meta;
		next_neg_meta   = negative_pin_i;
		next_neg_sync   = neg_meta;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmp_meta   <= 1'b0;
			cmp_result <= 1'b0;
			cmp_prev   <= 1'b0;
			pos_meta   <= 1'b0;
			pos_sync   <= 1'b0;
			neg_meta   <= 1'b0;
			neg_sync   <= 1'b0;
		end else begin
			cmp_meta   <= next_cmp_meta;
			cmp_result <= next_cmp_result;
			cmp_prev   <= next_cmp_prev;
			pos_meta   <= next_pos_meta;
			pos_sync   <= next_pos_sync;
			neg_meta   <= next_neg_meta;
			neg_sync   <= next_neg_sync;
		end
	end

	// ---------------------------------------------------------------
	// APB decode. One wait state: pready rises in the second access
	// cycle so prdata can come straight from a flop.
	// ---------------------------------------------------------------
	always_comb begin
		hit_cb   = (paddr_i[11:2] == `CCL_IDX_CONV_CTRL_B);
		hit_cs   = (paddr_i[11:2] == `CCL_IDX_CTRL_STATUS);
		hit_pd   = (paddr_i[11:2] == `CCL_IDX_PIN_IN_DISABLE);
		mapped   = (hit_cb | hit_cs | hit_pd) & (paddr_i[1:0] == 2'h0);
		commit   = psel_i & penable_i & pready_o;
		wr_lane0 = commit & pwrite_i & pstrb_i[0] & mapped;
	end

	// Event selection from the synchronised result
	always_comb begin
		unique case (ctrl.irq_mode)
			CCL_MODE_TOGGLE: event_hit = cmp_result ^ cmp_prev;
			CCL_MODE_RSVD:   event_hit = 1'b0;
			CCL_MODE_FALL:   event_hit = cmp_prev & ~cmp_result;
			CCL_MODE_RISE:   event_hit = ~cmp_prev & cmp_result;
		endcase
	end

	// Read views; reserved bits read zero
	always_comb begin
		cs_read = 8'h00;
		cs_read[`CCL_CS_DISABLE] = ctrl.comparator_disable;
		cs_read[`CCL_CS_BANDGAP] = ctrl.bandgap_select;
		cs_read[`CCL_CS_RESULT]  = cmp_result;
		cs_read[`CCL_CS_FLAG]    = ctrl.comparator_irq_flag;
		cs_read[`CCL_CS_IRQ_EN]  = ctrl.comparator_irq_enable;
		cs_read[`CCL_CS_CAPTURE] = ctrl.capture_route_enable;
		cs_read[`CCL_CS_MODE_HI:`CCL_CS_MODE_LO] = ctrl.irq_mode;
		cb_read = 8'h00;
		cb_read[`CCL_CB_MUX_EN] = conv_b.negative_mux_enable;
		cb_read[`CCL_CB_SEL_HI] = conv_b.neg_select_high;
		cb_read[`CCL_CB_TRIG_HI:`CCL_CB_TRIG_LO] = conv_b.trigger_src;
	end

	// ---------------------------------------------------------------
	// Register next values
	// ---------------------------------------------------------------
	always_comb begin
		next_ctrl    = ctrl;
		next_conv_b  = conv_b;
		next_pin_dis = pin_dis;
		flag_clear   = irq_vector_ack_i;
		if (wr_lane0 && hit_cs) begin
			next_ctrl.comparator_disable    = pwdata_i[`CCL_CS_DISABLE];
			next_ctrl.bandgap_select        = pwdata_i[`CCL_CS_BANDGAP];
			next_ctrl.comparator_irq_enable = pwdata_i[`CCL_CS_IRQ_EN];
			next_ctrl.capture_route_enable  = pwdata_i[`CCL_CS_CAPTURE];
			next_ctrl.irq_mode = ccl_mode_e'(pwdata_i[`CCL_CS_MODE_HI:`CCL_CS_MODE_LO]);
			if (pwdata_i[`CCL_CS_FLAG]) begin
				flag_clear = 1'b1;
			end
		end
		if (wr_lane0 && hit_cb) begin
			next_conv_b.negative_mux_enable = pwdata_i[`CCL_CB_MUX_EN];
			next_conv_b.neg_select_high     = pwdata_i[`CCL_CB_SEL_HI];
			next_conv_b.trigger_src = pwdata_i[`CCL_CB_TRIG_HI:`CCL_CB_TRIG_LO];
		end
		if (wr_lane0 && hit_pd) begin
			next_pin_dis = pwdata_i[`CCL_PD_NEG:`CCL_PD_POS];
		end
		// A new event outranks a clear in the same cycle so none is lost
		if (event_hit) begin
			next_ctrl.comparator_irq_flag = 1'b1;
		end else if (flag_clear) begin
			next_ctrl.comparator_irq_flag = 1'b0;
		end
	end

	// Bus response next values
	always_comb begin
		next_pready  = psel_i & penable_i & ~pready_o;
		next_prdata  = `CCL_WORD_ZERO;
		next_pslverr = 1'b0;
		if (next_pready) begin
			next_pslverr = ~mapped;
			if (!pwrite_i && mapped) begin
				if (hit_cs) begin
					next_prdata[7:0] = cs_read;
				end else if (hit_cb) begin
					next_prdata[7:0] = cb_read;
				end else begin
					next_prdata[1:0] = pin_dis;
				end
			end
		end
	end

	// Outward control next values
	always_comb begin
		next_irq = ctrl.comparator_irq_flag & ctrl.comparator_irq_enable
			& global_irq_enable_i;
		// Converter must be off because its mux is borrowed
		next_neg_sel.use_mux = conv_b.negative_mux_enable & ~converter_enable_i;
		next_neg_sel.channel = next_neg_sel.use_mux ?
			{conv_b.neg_select_high, neg_select_low_i} : 4'h0;
		next_capture      = ctrl.capture_route_enable & cmp_result;
		next_positive_pin = pos_sync & ~pin_dis[`CCL_PD_POS];
		next_negative_pin = neg_sync & ~pin_dis[`CCL_PD_NEG];
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl                 <= '{default: '0, irq_mode: CCL_MODE_TOGGLE};
			conv_b               <= ccl_conv_b_s'(5'(`CCL_CB_RESET));
			pin_dis              <= `CCL_PD_RESET;
			prdata_o             <= `CCL_WORD_ZERO;
			pready_o             <= 1'b0;
			pslverr_o            <= 1'b0;
			irq_o                <= 1'b0;
			capture_o            <= 1'b0;
			neg_sel_o            <= '0;
			comparator_disable_o <= 1'b0;
			bandgap_select_o     <= 1'b0;
			trigger_src_o        <= 3'h0;
			pos_pin_buffer_off_o <= 1'b0;
			neg_pin_buffer_off_o <= 1'b0;
			positive_pin_o       <= 1'b0;
			negative_pin_o       <= 1'b0;
		end else begin
			ctrl                 <= next_ctrl;
			conv_b               <= next_conv_b;
			pin_dis              <= next_pin_dis;
			prdata_o             <= next_prdata;
			pready_o             <= next_pready;
			pslverr_o            <= next_pslverr;
			irq_o                <= next_irq;
			capture_o            <= next_capture;
			neg_sel_o            <= next_neg_sel;
			comparator_disable_o <= ctrl.comparator_disable;
			bandgap_select_o     <= ctrl.bandgap_select;
			trigger_src_o        <= conv_b.trigger_src;
			pos_pin_buffer_off_o <= pin_dis[`CCL_PD_POS];
			neg_pin_buffer_off_o <= pin_dis[`CCL_PD_NEG];
			positive_pin_o       <= next_positive_pin;
			negative_pin_o       <= next_negative_pin;
		end
	end

endmodule : ccl_comparator_ctrl

`default_nettype wire

// file: ccl_comparator_ctrl_checker.sv
`default_nettype none

module ccl_comparator_ctrl_checker (
	input wire logic                  clk_i,
	input wire logic                  nrst_i,
	input wire logic                  psel_i,
	input wire logic                  penable_i,
	input wire logic [31:0]           prdata_o,
	input wire logic                  pready_o,
	input wire logic                  pslverr_o,
	input wire logic                  cmp_raw_i,
	input wire ccl_pkg::ccl_neg_sel_s neg_sel_o,
	input wire logic                  converter_enable_i,
	input wire logic [2:0]            neg_select_low_i,
	input wire logic                  global_irq_enable_i,
	input wire logic                  irq_o,
	input wire logic                  capture_o,
	input wire logic                  pos_pin_buffer_off_o,
	input wire logic                  positive_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	a_mux_bypass: assert property (converter_enable_i |=> !neg_sel_o.use_mux)
		else $error("mux kept while converter on");
	a_chan_idle: assert property (!neg_sel_o.use_mux |-> neg_sel_o.channel == 4'h0)
		else $error("channel not zero on dedicated pin");
	a_chan_low: assert property (
		neg_sel_o.use_mux |-> neg_sel_o.channel[2:0] == $past(neg_select_low_i))
		else $error("channel low bits wrong");
	a_pin_off: assert property (
		pos_pin_buffer_off_o && $past(pos_pin_buffer_off_o) |-> !positive_pin_o)
		else $error("disabled pin reads one");
	a_irq_gate: assert property (irq_o |-> $past(global_irq_enable_i))
		else $error("irq without global enable");
	a_ready_wait: assert property (
		psel_i && penable_i && !pready_o && !$past(penable_i) |=> pready_o)
		else $error("pready not in second access cycle");
	a_read_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
		else $error("read data outside ready cycle");
	a_capture_lag: assert property (
		capture_o |-> $past(cmp_raw_i, 2) || $past(cmp_raw_i, 3))
		else $error("capture without synced result");

	c_irq: cover property (irq_o);
	c_mux: cover property (neg_sel_o.use_mux);
	c_err: cover property (pslverr_o);
endmodule : ccl_comparator_ctrl_checker

`default_nettype wire

// file: ccl_comparator_ctrl_tb.sv
`default_nettype none
`include "ccl_cfg.svh"

module ccl_comparator_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ccl_pkg::*;

	localparam logic [11:0] A_CB = {`CCL_IDX_CONV_CTRL_B, 2'b00};
	localparam logic [11:0] A_CS = {`CCL_IDX_CTRL_STATUS, 2'b00};
	localparam logic [11:0] A_PD = {`CCL_IDX_PIN_IN_DISABLE, 2'b00};

	logic         clk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0]  paddr_i = 12'h000;
	logic [31:0]  pwdata_i = 32'h0000_0000, prdata_o, rdata;
	logic [3:0]   pstrb_i = 4'hf;
	logic         converter_enable_i = 1'b0, global_irq_enable_i = 1'b0, irq_vector_ack_i = 1'b0;
	logic [2:0]   neg_select_low_i = 3'h0;
	logic [2:0]   trigger_src_o;
	logic         positive_pin_i = 1'b1, negative_pin_i = 1'b1, pready_o, pslverr_o, rerr;
	logic         cmp_raw_i, comparator_disable_o, bandgap_select_o, irq_o, capture_o;
	logic         pos_pin_buffer_off_o, neg_pin_buffer_off_o, positive_pin_o, negative_pin_o;
	ccl_neg_sel_s neg_sel_o;
	int           pos_mv = 100, neg_mv = 500, error_cnt = 0, n_checks = 0;

	ccl_comparator_ctrl dut_u (
		.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
		.prdata_o, .pready_o, .pslverr_o, .cmp_raw_i, .comparator_disable_o, .bandgap_select_o,
		.neg_sel_o, .converter_enable_i, .neg_select_low_i, .trigger_src_o,
		.global_irq_enable_i, .irq_vector_ack_i, .irq_o, .capture_o, .positive_pin_i,
		.negative_pin_i, .pos_pin_buffer_off_o, .neg_pin_buffer_off_o, .positive_pin_o,
		.negative_pin_o
	);

	ccl_analog_model mdl_u (
		.dis_i (comparator_disable_o), .bg_i (bandgap_select_o), .sel_i (neg_sel_o),
		.pos_mv_i (pos_mv), .neg_mv_i (neg_mv), .raw_o (cmp_raw_i)
	);

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	task automatic tally_and_finish();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	// Idle edge first, so a released psel is never re-driven in the same step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		psel_i   <= 1'b1;
		pwrite_i <= w;
		paddr_i  <= a;
		pwdata_i <= {24'h00_0000, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		for (k = 0; k < 20 && pready_o !== 1'b1; k++) @(posedge clk_i);
		if (k >= 20) begin
			error_cnt++;
			$display("[FAIL] pready exp 1 got 0");
			tally_and_finish();
		end
		rdata = prdata_o;
		rerr  = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask : xfer

	initial begin
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'b1;
		xfer(0, A_CS, 8'h00);
		chk("cs reset", 8'h00, rdata);
		xfer(0, 12'h004, 8'h00);
		chk("unmapped", 1'b1, rerr);
		pos_mv <= 750;
		for (int c = 0; c < 16; c++) begin
			neg_select_low_i <= c[2:0];
			xfer(1, A_CB, {4'h4, c[3], 3'h0});
			repeat (4) @(posedge clk_i);
			chk("neg sel", {1'b1, c[3:0]}, neg_sel_o);
			xfer(0, A_CS, 8'h00);
			chk("mux result", (c < 8) ? 8'h20 : 8'h00, rdata & 8'h20);
		end
		converter_enable_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk("bypass", 1'b0, neg_sel_o.use_mux);
		pos_mv <= 100;
		xfer(1, A_CS, 8'h10);
		xfer(1, A_CS, 8'h40);
		repeat (4) @(posedge clk_i);
		chk("bg sel", 1'b1, bandgap_select_o);
		xfer(1, A_CS, 8'h40);
		xfer(0, A_CS, 8'h00);
		chk("bandgap", 8'h70, rdata);
		xfer(1, A_CS, 8'h50);
		xfer(0, A_CS, 8'h00);
		chk("w1c", 8'h60, rdata);
		// Converter stays on here, so the mux select cannot move the comparator
		xfer(1, A_CB, 8'hff);
		xfer(0, A_CB, 8'h00);
		chk("cb read", 8'h4f, rdata);
		chk("trigger", 3'h7, trigger_src_o);
		xfer(1, A_CS, 8'h00);
		for (int m = 0; m < 4; m++) begin
			xfer(1, A_CS, {6'h04, m[1:0]});
			pos_mv <= 900;
			repeat (5) @(posedge clk_i);
			xfer(0, A_CS, 8'h00);
			chk("rise flag", (m == 0 || m == 3) ? 8'h30 : 8'h20, rdata & 8'h30);
			xfer(1, A_CS, {6'h04, m[1:0]});
			pos_mv <= 100;
			repeat (5) @(posedge clk_i);
			xfer(0, A_CS, 8'h00);
			chk("fall flag", (m == 0 || m == 2) ? 8'h10 : 8'h00, rdata & 8'h30);
		end
		xfer(1, A_CS, 8'h0b);
		pos_mv <= 900;
		repeat (6) @(posedge clk_i);
		chk("irq masked", 1'b0, irq_o);
		global_irq_enable_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("irq on", 1'b1, irq_o);
		irq_vector_ack_i <= 1'b1;
		@(posedge clk_i);
		irq_vector_ack_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("irq acked", 1'b0, irq_o);
		xfer(1, A_CS, 8'h03);
		xfer(1, A_CS, 8'h83);
		repeat (2) @(posedge clk_i);
		chk("cmp off", 1'b1, comparator_disable_o);
		xfer(1, A_CS, 8'h07);
		repeat (5) @(posedge clk_i);
		chk("cmp on", 1'b0, comparator_disable_o);
		chk("capture on", 1'b1, capture_o);
		xfer(1, A_CS, 8'h03);
		repeat (3) @(posedge clk_i);
		chk("capture off", 1'b0, capture_o);
		xfer(1, A_PD, 8'h02);
		repeat (4) @(posedge clk_i);
		chk("pins", 4'b1001, {neg_pin_buffer_off_o, pos_pin_buffer_off_o,
			negative_pin_o, positive_pin_o});
		pstrb_i <= 4'h0;
		xfer(1, A_PD, 8'h01);
		xfer(0, A_PD, 8'h00);
		chk("pd strobe", 8'h02, rdata);
		pstrb_i <= 4'hf;
		xfer(1, A_PD, 8'h01);
		repeat (2) @(posedge clk_i);
		chk("pos pin off", 4'b0110, {neg_pin_buffer_off_o, pos_pin_buffer_off_o,
			negative_pin_o, positive_pin_o});
		tally_and_finish();
	end
endmodule : ccl_comparator_ctrl_tb

bind ccl_comparator_ctrl ccl_comparator_ctrl_checker chk_u (
	.clk_i, .nrst_i, .psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o, .cmp_raw_i,
	.neg_sel_o, .converter_enable_i, .neg_select_low_i, .global_irq_enable_i, .irq_o,
	.capture_o, .pos_pin_buffer_off_o, .positive_pin_o
);

`default_nettype wire

// file: ccl_pkg.sv
`default_nettype none
`include "ccl_cfg.svh"

package ccl_pkg;

	typedef enum logic [1:0] {
		CCL_MODE_TOGGLE = 2'b00,
		CCL_MODE_RSVD   = 2'b01,
		CCL_MODE_FALL   = 2'b10,
		CCL_MODE_RISE   = 2'b11
	} ccl_mode_e;

	// Negative comparator input selection handed to the analog mux
	typedef struct packed {
		logic       use_mux;
		logic [3:0] channel;
	} ccl_neg_sel_s;

	// Writable and hardware-set control state of comparator_ctrl_status
	typedef struct packed {
		logic      comparator_disable;
		logic      bandgap_select;
		logic      comparator_irq_flag;
		logic      comparator_irq_enable;
		logic      capture_route_enable;
		ccl_mode_e irq_mode;
	} ccl_ctrl_s;

	// converter_ctrl_b stored fields
	typedef struct packed {
		logic       negative_mux_enable;
		logic       neg_select_high;
		logic [2:0] trigger_src;
	} ccl_conv_b_s;

endpackage : ccl_pkg

`default_nettype wire
